// >>> src/cci_pkg.sv
// Package of constants and types for the cascaded 32-bit input capture block
package cci_pkg;

  localparam int CCI_AW = 5;

  // Register indices (word address on the plain register port)
  localparam logic [4:0] CCI_OFS_HIGH_COUNTER   = 5'h00;
  localparam logic [4:0] CCI_OFS_LOW_COUNTER    = 5'h01;
  localparam logic [4:0] CCI_OFS_HIGH_CAPTURE   = 5'h02;
  localparam logic [4:0] CCI_OFS_LOW_CAPTURE    = 5'h03;
  localparam logic [4:0] CCI_OFS_HIGH_IO_CTRL   = 5'h04;
  localparam logic [4:0] CCI_OFS_LOW_IO_CTRL    = 5'h05;
  localparam logic [4:0] CCI_OFS_HIGH_IRQ_EN    = 5'h06;
  localparam logic [4:0] CCI_OFS_LOW_IRQ_EN     = 5'h07;
  localparam logic [4:0] CCI_OFS_HIGH_MODE      = 5'h08;
  localparam logic [4:0] CCI_OFS_LOW_MODE       = 5'h09;
  localparam logic [4:0] CCI_OFS_HIGH_CTRL      = 5'h0a;
  localparam logic [4:0] CCI_OFS_LOW_CTRL       = 5'h0b;
  localparam logic [4:0] CCI_OFS_CASCADE_COND   = 5'h0c;
  localparam logic [4:0] CCI_OFS_RUN_CONTROL    = 5'h0d;
  localparam logic [4:0] CCI_OFS_HIGH_STATUS    = 5'h0e;
  localparam logic [4:0] CCI_OFS_LOW_STATUS     = 5'h0f;

  // Field positions
  localparam int CCI_PSC_LSB        = 0;   // prescaler_select in counter control
  localparam int CCI_IOA_LSB        = 0;   // latch_a_function in io control
  localparam int CCI_IE_CAPA_BIT    = 0;   // capture A interrupt enable
  localparam int CCI_IE_OVF_BIT     = 4;   // overflow interrupt enable
  localparam int CCI_IE_UNF_BIT     = 5;   // underflow interrupt enable
  localparam int CCI_IE_ADC_BIT     = 7;   // converter start enable
  localparam int CCI_ST_CAPA_BIT    = 0;   // capture flag in status
  localparam int CCI_ST_OVF_BIT     = 4;   // overflow_flag in status
  localparam int CCI_ST_UNF_BIT     = 5;   // underflow_flag in status
  localparam int CCI_CC_LOW_TRIG_HI = 2;   // low_pin_triggers_high
  localparam int CCI_RUN_HIGH_BIT   = 1;   // run bit of the high channel
  localparam int CCI_RUN_LOW_BIT    = 2;   // run bit of the low channel

  // Codes
  localparam logic [2:0] CCI_PSC_CASCADE  = 3'h7;
  localparam logic [3:0] CCI_IOA_CAP_RISE = 4'h8;

  // Reset values
  localparam logic [15:0] CCI_RST_HALF = 16'h0000;
  localparam logic [7:0]  CCI_RST_BYTE = 8'h00;

  // Capture event bundle between pin stage and core
  typedef struct packed {
    logic rise;   // synchronised rising edge on the pin
    logic level;  // synchronised pin level
  } cci_pin_event_type;

endpackage : cci_pkg

// >>> src/cci_pin_sync.sv
// Two-stage synchroniser and rising-edge detector for the capture pin
`timescale 1ns/10ps
`default_nettype none
module cci_pin_sync
  import cci_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              pin_in,
  output cci_pin_event_type      pin_evt
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_evt.rise  = sync_q & ~prev_q;
  assign pin_evt.level = sync_q;

endmodule : cci_pin_sync
`default_nettype wire

// >>> src/cci_half_counter.sv
// One 16-bit half of the chained counter with software load
`timescale 1ns/10ps
`default_nettype none
module cci_half_counter
  import cci_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             count_en,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count_q,
  output logic                  wrap
);

  logic [WIDTH-1:0] count_d;

  // Wrap is combinational so the carry reaches the other half in the same cycle;
  // a software load wins over counting, so it must not leak a false carry
  assign wrap    = count_en & ~load & (&count_q);
  assign count_d = load ? load_val : (count_en ? count_q + 1'b1 : count_q);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : cci_half_counter
`default_nettype wire

// >>> src/cci_capture_top.sv
// Cascaded 32-bit input capture timer: two 16-bit channels and registers
//
// Contract
// - High counter holds upper 16 bits, low counter the lower 16 bits.
// - Low counter advances on the timer module clock.
// - High counter increments only on low counter wrap when cascaded.
// - Low channel captures on a rising edge of the capture pin.
// - Capture sets the flag and raises an interrupt when enabled.
// - High capture follows the low pin when the cascade register selects it.
// - High and low captures occur in the same cycle.
// - Each capture copies its counter into its own latch A.
// - Both counters are 16-bit software read/write registers.
// - Both capture latches are 16-bit software read/write registers.
// - Each channel has an 8-bit read/write io control register.
// - Each channel has an 8-bit interrupt enable register.
// - An 8-bit cascade capture condition register selects cross triggers.
// - Each channel has an 8-bit counter control register.
// - Each channel has an 8-bit mode register.
// - Shared run register; a counter advances only while its bit is set.
// - Prescaler code 111 in high control selects low wrap as clock.
// - Io code 1000 makes latch A a rising-edge input capture.
// - Cascade bit 2 lets the low pin trigger the high latch A capture.
`timescale 1ns/10ps
`default_nettype none
module cci_capture_top
  import cci_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [CCI_AW-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              capture_input_pin,
  output logic                   low_capture_irq,
  output logic                   high_capture_irq,
  output logic                   overflow_irq,
  output logic                   adc_start_req
);

  // Control registers
  logic [7:0]  high_io_control_q, low_io_control_q;
  logic [7:0]  high_irq_enable_q, low_irq_enable_q;
  logic [7:0]  high_mode_select_q, low_mode_select_q;
  logic [7:0]  high_counter_control_q, low_counter_control_q;
  logic [7:0]  cascade_capture_condition_q;
  logic [7:0]  counter_run_control_q;
  logic [15:0] high_capture_latch_q, low_capture_latch_q;
  logic        low_cap_flag_q, high_cap_flag_q, low_ovf_flag_q;
  logic [15:0] high_half_counter, low_half_counter;
  logic        low_wrap;
  cci_pin_event_type pin_evt;

  // Address decode
  wire sel_hcnt  = (reg_addr == CCI_OFS_HIGH_COUNTER);
  wire sel_lcnt  = (reg_addr == CCI_OFS_LOW_COUNTER);
  wire sel_hcap  = (reg_addr == CCI_OFS_HIGH_CAPTURE);
  wire sel_lcap  = (reg_addr == CCI_OFS_LOW_CAPTURE);
  wire sel_hio   = (reg_addr == CCI_OFS_HIGH_IO_CTRL);
  wire sel_lio   = (reg_addr == CCI_OFS_LOW_IO_CTRL);
  wire sel_hie   = (reg_addr == CCI_OFS_HIGH_IRQ_EN);
  wire sel_lie   = (reg_addr == CCI_OFS_LOW_IRQ_EN);
  wire sel_hmd   = (reg_addr == CCI_OFS_HIGH_MODE);
  wire sel_lmd   = (reg_addr == CCI_OFS_LOW_MODE);
  wire sel_hcr   = (reg_addr == CCI_OFS_HIGH_CTRL);
  wire sel_lcr   = (reg_addr == CCI_OFS_LOW_CTRL);
  wire sel_cc    = (reg_addr == CCI_OFS_CASCADE_COND);
  wire sel_run   = (reg_addr == CCI_OFS_RUN_CONTROL);
  wire sel_hst   = (reg_addr == CCI_OFS_HIGH_STATUS);
  wire sel_lst   = (reg_addr == CCI_OFS_LOW_STATUS);

  // Pin synchroniser and edge detect
  cci_pin_sync u_pin (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pin_in  (capture_input_pin),
    .pin_evt (pin_evt)
  );

  // Counting enables; only the prescaler and run bits gate them
  wire low_run   = counter_run_control_q[CCI_RUN_LOW_BIT];
  wire high_run  = counter_run_control_q[CCI_RUN_HIGH_BIT];
  wire low_cnt_en = low_run;                                 // timer_module_clock = mclk
  wire high_cascaded = (high_counter_control_q[CCI_PSC_LSB +: 3] == CCI_PSC_CASCADE);
  // In cascade mode the high half only sees the low carry; other sources use mclk
  wire high_cnt_en = high_run & (high_cascaded ? low_wrap : 1'b1);

  cci_half_counter #(.WIDTH(16)) u_low (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .count_en (low_cnt_en),
    .load     (reg_wr & sel_lcnt),
    .load_val (reg_wdata),
    .count_q  (low_half_counter),
    .wrap     (low_wrap)
  );

  cci_half_counter #(.WIDTH(16)) u_high (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .count_en (high_cnt_en),
    .load     (reg_wr & sel_hcnt),
    .load_val (reg_wdata),
    .count_q  (high_half_counter),
    .wrap     ()
  );

  // Capture triggers: both latches fire on the same edge event
  wire low_ioa_cap  = (low_io_control_q[CCI_IOA_LSB +: 4] == CCI_IOA_CAP_RISE);
  wire high_ioa_cap = (high_io_control_q[CCI_IOA_LSB +: 4] == CCI_IOA_CAP_RISE);
  wire low_cap      = pin_evt.rise & low_ioa_cap;
  wire high_cap     = pin_evt.rise & high_ioa_cap
                    & cascade_capture_condition_q[CCI_CC_LOW_TRIG_HI];

  // Flag clear: writing zero to a flag bit of the status register clears it
  wire lst_wr   = reg_wr & sel_lst;
  wire hst_wr   = reg_wr & sel_hst;
  wire low_cap_clr  = lst_wr & ~reg_wdata[CCI_ST_CAPA_BIT];
  wire high_cap_clr = hst_wr & ~reg_wdata[CCI_ST_CAPA_BIT];
  wire low_ovf_clr  = lst_wr & ~reg_wdata[CCI_ST_OVF_BIT];

  // Sticky flags; a set in the clear cycle wins so no event is lost
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      low_cap_flag_q  <= 1'b0;
      high_cap_flag_q <= 1'b0;
      low_ovf_flag_q  <= 1'b0;
    end else begin
      low_cap_flag_q  <= low_cap  | (low_cap_flag_q  & ~low_cap_clr);
      high_cap_flag_q <= high_cap | (high_cap_flag_q & ~high_cap_clr);
      low_ovf_flag_q  <= low_wrap | (low_ovf_flag_q  & ~low_ovf_clr);
    end
  end

  // Capture latches copy the counters; a capture outranks a software write
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      low_capture_latch_q  <= CCI_RST_HALF;
      high_capture_latch_q <= CCI_RST_HALF;
    end else begin
      if (low_cap) begin
        low_capture_latch_q <= low_half_counter;
      end else if (reg_wr && sel_lcap) begin
        low_capture_latch_q <= reg_wdata;
      end
      if (high_cap) begin
        high_capture_latch_q <= high_half_counter;
      end else if (reg_wr && sel_hcap) begin
        high_capture_latch_q <= reg_wdata;
      end
    end
  end

  // Byte-wide control registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      high_io_control_q           <= CCI_RST_BYTE;
      low_io_control_q            <= CCI_RST_BYTE;
      high_irq_enable_q           <= CCI_RST_BYTE;
      low_irq_enable_q            <= CCI_RST_BYTE;
      high_mode_select_q          <= CCI_RST_BYTE;
      low_mode_select_q           <= CCI_RST_BYTE;
      high_counter_control_q      <= CCI_RST_BYTE;
      low_counter_control_q       <= CCI_RST_BYTE;
      cascade_capture_condition_q <= CCI_RST_BYTE;
      counter_run_control_q       <= CCI_RST_BYTE;
    end else if (reg_wr) begin
      if (sel_hio) high_io_control_q <= reg_wdata[7:0];
      if (sel_lio) low_io_control_q <= reg_wdata[7:0];
      if (sel_hie) high_irq_enable_q <= reg_wdata[7:0];
      if (sel_lie) low_irq_enable_q <= reg_wdata[7:0];
      if (sel_hmd) high_mode_select_q <= reg_wdata[7:0];
      if (sel_lmd) low_mode_select_q <= reg_wdata[7:0];
      if (sel_hcr) high_counter_control_q <= reg_wdata[7:0];
      if (sel_lcr) low_counter_control_q <= reg_wdata[7:0];
      if (sel_cc) cascade_capture_condition_q <= reg_wdata[7:0];
      if (sel_run) counter_run_control_q <= reg_wdata[7:0];
    end
  end

  // Status words show flags; the overflow flag lives in the low channel only
  wire [15:0] low_status  = 16'h0000
                          | (16'(low_cap_flag_q) << CCI_ST_CAPA_BIT)
                          | (16'(low_ovf_flag_q) << CCI_ST_OVF_BIT);
  wire [15:0] high_status = 16'(high_cap_flag_q) << CCI_ST_CAPA_BIT;

  // Read mux; unmapped addresses read as zero
  logic [15:0] rdata_d;
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      CCI_OFS_HIGH_COUNTER: rdata_d = high_half_counter;
      CCI_OFS_LOW_COUNTER:  rdata_d = low_half_counter;
      CCI_OFS_HIGH_CAPTURE: rdata_d = high_capture_latch_q;
      CCI_OFS_LOW_CAPTURE:  rdata_d = low_capture_latch_q;
      CCI_OFS_HIGH_IO_CTRL: rdata_d = {8'h00, high_io_control_q};
      CCI_OFS_LOW_IO_CTRL:  rdata_d = {8'h00, low_io_control_q};
      CCI_OFS_HIGH_IRQ_EN:  rdata_d = {8'h00, high_irq_enable_q};
      CCI_OFS_LOW_IRQ_EN:   rdata_d = {8'h00, low_irq_enable_q};
      CCI_OFS_HIGH_MODE:    rdata_d = {8'h00, high_mode_select_q};
      CCI_OFS_LOW_MODE:     rdata_d = {8'h00, low_mode_select_q};
      CCI_OFS_HIGH_CTRL:    rdata_d = {8'h00, high_counter_control_q};
      CCI_OFS_LOW_CTRL:     rdata_d = {8'h00, low_counter_control_q};
      CCI_OFS_CASCADE_COND: rdata_d = {8'h00, cascade_capture_condition_q};
      CCI_OFS_RUN_CONTROL:  rdata_d = {8'h00, counter_run_control_q};
      CCI_OFS_HIGH_STATUS:  rdata_d = high_status;
      CCI_OFS_LOW_STATUS:   rdata_d = low_status;
      default:              rdata_d = 16'h0000;
    endcase
  end

  // Request outputs are registered levels that follow flag and enable
  wire low_irq_d  = low_cap_flag_q & low_irq_enable_q[CCI_IE_CAPA_BIT];
  wire high_irq_d = high_cap_flag_q & high_irq_enable_q[CCI_IE_CAPA_BIT];
  wire ovf_irq_d  = low_ovf_flag_q & low_irq_enable_q[CCI_IE_OVF_BIT];
  // Converter start is a one-cycle pulse on any enabled latch A capture
  wire adc_d      = (low_cap & low_irq_enable_q[CCI_IE_ADC_BIT])
                  | (high_cap & high_irq_enable_q[CCI_IE_ADC_BIT]);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata        <= 16'h0000;
      low_capture_irq  <= 1'b0;
      high_capture_irq <= 1'b0;
      overflow_irq     <= 1'b0;
      adc_start_req    <= 1'b0;
    end else begin
      reg_rdata        <= reg_rd ? rdata_d : 16'h0000;
      low_capture_irq  <= low_irq_d;
      high_capture_irq <= high_irq_d;
      overflow_irq     <= ovf_irq_d;
      adc_start_req    <= adc_d;
    end
  end

endmodule : cci_capture_top
`default_nettype wire

// >>> dv/cci_capture_checker.sv
// Port-level assertion checker for the cascaded capture block
`timescale 1ns/10ps
`default_nettype none
module cci_capture_checker
  import cci_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [CCI_AW-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              capture_input_pin,
  input wire logic              low_capture_irq,
  input wire logic              high_capture_irq,
  input wire logic              overflow_irq,
  input wire logic              adc_start_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [7:0] low_en_q;
  logic [7:0] high_en_q;
  logic [7:0] low_io_q;
  // Shadows of the enables and the low io control, so the irq checks need no view of internals
  always_ff @(posedge mclk)
    if (!rst_b) low_en_q <= 8'h00;
    else if (reg_wr && reg_addr == CCI_OFS_LOW_IRQ_EN) low_en_q <= reg_wdata[7:0];
  always_ff @(posedge mclk)
    if (!rst_b) high_en_q <= 8'h00;
    else if (reg_wr && reg_addr == CCI_OFS_HIGH_IRQ_EN) high_en_q <= reg_wdata[7:0];
  always_ff @(posedge mclk)
    if (!rst_b) low_io_q <= 8'h00;
    else if (reg_wr && reg_addr == CCI_OFS_LOW_IO_CTRL) low_io_q <= reg_wdata[7:0];

  // Read data only in the cycle after a read strobe
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");
  property p_byte_regs;
    reg_rd && reg_addr >= CCI_OFS_HIGH_IO_CTRL && reg_addr <= CCI_OFS_RUN_CONTROL
      |=> reg_rdata[15:8] == 8'h00;
  endproperty
  a_byte_regs: assert property (p_byte_regs)
    else $error("byte register read shows upper bits");
  // Pin first sampled high at c1 gives the converter pulse sampled at c4
  property p_rise_to_adc; adc_start_req |-> $past(capture_input_pin, 3) && !$past(capture_input_pin, 4); endproperty
  a_rise_to_adc: assert property (p_rise_to_adc)
    else $error("converter pulse without a pin rise four cycles before");
  property p_adc_pulse; adc_start_req |=> !adc_start_req; endproperty
  a_adc_pulse: assert property (p_adc_pulse)
    else $error("converter pulse longer than one cycle");
  property p_low_irq_en; low_capture_irq |-> $past(low_en_q[0]); endproperty
  a_low_irq_en: assert property (p_low_irq_en)
    else $error("low capture irq while disabled");
  property p_high_irq_en; high_capture_irq |-> $past(high_en_q[0]); endproperty
  a_high_irq_en: assert property (p_high_irq_en)
    else $error("high capture irq while disabled");
  property p_ovf_en; overflow_irq |-> $past(low_en_q[4]); endproperty
  a_ovf_en: assert property (p_ovf_en)
    else $error("overflow irq while disabled");
  property p_irq_after_cap;
    adc_start_req && low_en_q[0] && low_en_q[7] && low_io_q[3:0] == 4'h8 |=> low_capture_irq;
  endproperty
  a_irq_after_cap: assert property (p_irq_after_cap)
    else $error("low capture irq missing after capture");
  property p_irq_fall;
    $fell(low_capture_irq) |-> $past(reg_wr, 2) && ($past(reg_addr, 2) == CCI_OFS_LOW_STATUS
      || $past(reg_addr, 2) == CCI_OFS_LOW_IRQ_EN);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("low capture irq dropped without a software write");
  c_capture: cover property (adc_start_req);
  c_both_irq: cover property (low_capture_irq && high_capture_irq);
  c_ovf: cover property (overflow_irq);
endmodule // cci_capture_checker

bind cci_capture_top cci_capture_checker u_chk (.mclk(mclk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .capture_input_pin(capture_input_pin),
  .low_capture_irq(low_capture_irq), .high_capture_irq(high_capture_irq),
  .overflow_irq(overflow_irq), .adc_start_req(adc_start_req));
`default_nettype wire

// >>> dv/cci_pulse_src.sv
// Model of the external pulse source on the capture pin
`timescale 1ns/10ps
`default_nettype none
module cci_pulse_src (
  input  wire logic mclk,
  output var  logic pin
);
  // Idle low, so the first pulse is a clean rising edge
  initial pin = 1'b0;
  // Both phases last at least two cycles, else the synchroniser may miss them
  task automatic pulse(input int hi_cycles);
    @(posedge mclk);
    pin <= 1'b1;
    repeat (hi_cycles) @(posedge mclk);
    pin <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule // cci_pulse_src
`default_nettype wire

// >>> dv/tb_cascaded_32bit_input_capture.sv
// Self-checking bench for the cascaded 32-bit capture block
`timescale 1ns/10ps
`default_nettype none
module tb_cascaded_32bit_input_capture;
  import cci_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic [CCI_AW-1:0] reg_addr = 5'h00;
  logic [15:0]       reg_wdata = 16'h0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [15:0]       reg_rdata;
  logic              pin;
  logic              low_capture_irq;
  logic              high_capture_irq;
  logic              overflow_irq;
  logic              adc_start_req;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                adc_count = 0;
  int                cycles = 0;

  always #12.5 mclk = ~mclk;

  cci_capture_top u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_input_pin(pin), .low_capture_irq(low_capture_irq),
    .high_capture_irq(high_capture_irq), .overflow_irq(overflow_irq),
    .adc_start_req(adc_start_req));
  cci_pulse_src u_src (.mclk(mclk), .pin(pin));

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Count converter pulses; the cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cycles++;
    if (adc_start_req === 1'b1) adc_count++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 16; i++) rd_chk(i[4:0], 16'h0000);
    rd_chk(5'h1f, 16'h0000);
  endtask

  // Byte registers drop the upper byte; halves keep all 16 bits
  task automatic t_regs();
    for (int i = 4; i < 14; i++) begin
      wr(i[4:0], 16'hc3a0 | i[15:0]);
      rd_chk(i[4:0], 16'h00a0 | i[15:0]);
      wr(i[4:0], 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      wr(i[4:0], 16'h9e31 + i[15:0]);
      rd_chk(i[4:0], 16'h9e31 + i[15:0]);
    end
  endtask

  // Run for exactly two edges, then stop and read both halves
  task automatic t_carry(input logic [15:0] lo, input logic [15:0] exp_lo,
                         input logic [15:0] exp_hi, input logic exp_ovf);
    wr(CCI_OFS_HIGH_CTRL, 16'h0007);
    wr(CCI_OFS_LOW_IRQ_EN, 16'h0010);
    wr(CCI_OFS_HIGH_COUNTER, 16'h0005);
    wr(CCI_OFS_LOW_COUNTER, lo);
    wr(CCI_OFS_RUN_CONTROL, 16'h0006);
    wr(CCI_OFS_RUN_CONTROL, 16'h0000);
    rd_chk(CCI_OFS_LOW_COUNTER, exp_lo);
    rd_chk(CCI_OFS_HIGH_COUNTER, exp_hi);
    chk({15'h0000, overflow_irq}, {15'h0000, exp_ovf});
    wr(CCI_OFS_LOW_STATUS, 16'h0000);
    @(posedge mclk);
    #1 chk({15'h0000, overflow_irq}, 16'h0000);
  endtask

  // Counters stand still, so a latch that captures must hold the written counter value; one that does not keeps its last value
  task automatic t_capture(input logic [3:0] io, input logic [7:0] casc,
                           input logic [31:0] cnt, input logic [31:0] exp,
                           input logic [1:0] irqs, input int adcs);
    int base;
    base = adc_count;
    wr(CCI_OFS_HIGH_IO_CTRL, 16'h0008);
    wr(CCI_OFS_LOW_IO_CTRL, {12'h000, io});
    wr(CCI_OFS_HIGH_IRQ_EN, 16'h0001);
    wr(CCI_OFS_LOW_IRQ_EN, 16'h0081);
    wr(CCI_OFS_CASCADE_COND, {8'h00, casc});
    wr(CCI_OFS_HIGH_COUNTER, cnt[31:16]);
    wr(CCI_OFS_LOW_COUNTER, cnt[15:0]);
    u_src.pulse(3);
    repeat (6) @(posedge mclk);
    #1 chk({14'h0000, high_capture_irq, low_capture_irq}, {14'h0000, irqs});
    chk(adc_count[15:0] - base[15:0], adcs[15:0]);
    rd_chk(CCI_OFS_HIGH_CAPTURE, exp[31:16]);
    rd_chk(CCI_OFS_LOW_CAPTURE, exp[15:0]);
    wr(CCI_OFS_LOW_STATUS, 16'h0000);
    wr(CCI_OFS_HIGH_STATUS, 16'h0000);
    @(posedge mclk);
    #1 chk({14'h0000, high_capture_irq, low_capture_irq}, 16'h0000);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_carry(16'hfffe, 16'h0000, 16'h0006, 1'b1);
    t_carry(16'h0100, 16'h0102, 16'h0005, 1'b0);
    t_capture(4'h8, 8'h04, 32'habcd1234, 32'habcd1234, 2'b11, 1);
    t_capture(4'h8, 8'h00, 32'h11112222, 32'habcd2222, 2'b01, 1);
    t_capture(4'h9, 8'h04, 32'h33334444, 32'h33332222, 2'b10, 0);
    final_report();
  end
endmodule // tb_cascaded_32bit_input_capture
`default_nettype wire
